// ---- rtl/ofm_apb_regs.sv ----
/*
  APB slave holding the pending allocation words, control and status.
  Assumes a 32-bit APB master; zero wait states, unmapped reads give 0
  with pslverr.
*/
`timescale 1ns/1ps
`default_nettype none
module ofm_apb_regs (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [79:0] active_words,
  input  wire logic [8:0]  flags,
  input  wire logic        legacy_active,
  output logic [79:0]      pending_words,
  output logic             restart_pulse,
  output logic             profile_sel
);
  logic [79:0] words_reg;
  logic [79:0] words_next;
  logic        profile_reg;
  logic        profile_next;
  logic        restart_reg;
  logic        restart_next;
  logic [31:0] rdata;
  logic [31:0] prdata_next;
  logic        hit;
  logic        wr;

  always_comb begin
    words_next   = words_reg;
    profile_next = profile_reg;
    restart_next = 1'b0;
    prdata_next  = prdata;
    rdata        = 32'h0000_0000;
    hit          = 1'b1;
    wr           = psel && penable && pwrite;
    unique case (paddr)
      ofm_pkg::ADDR_ACCEL_GAIN:     rdata[15:0] = words_reg[15:0];
      ofm_pkg::ADDR_SPEED_INTEGRAL: rdata[15:0] = words_reg[31:16];
      ofm_pkg::ADDR_CURRENT_LIMITS: rdata[15:0] = words_reg[47:32];
      ofm_pkg::ADDR_BANK_LATCH:     rdata[15:0] = words_reg[63:48];
      ofm_pkg::ADDR_OUTPUTS:        rdata[15:0] = words_reg[79:64];
      ofm_pkg::ADDR_CONTROL:        rdata[1:0]  = {profile_reg, 1'b0};
      ofm_pkg::ADDR_STATUS:         rdata[9:0]  = {legacy_active, flags};
      ofm_pkg::ADDR_ACTIVE_BASE + ofm_pkg::ADDR_ACCEL_GAIN:
        rdata[15:0] = active_words[15:0];
      ofm_pkg::ADDR_ACTIVE_BASE + ofm_pkg::ADDR_SPEED_INTEGRAL:
        rdata[15:0] = active_words[31:16];
      ofm_pkg::ADDR_ACTIVE_BASE + ofm_pkg::ADDR_CURRENT_LIMITS:
        rdata[15:0] = active_words[47:32];
      ofm_pkg::ADDR_ACTIVE_BASE + ofm_pkg::ADDR_BANK_LATCH:
        rdata[15:0] = active_words[63:48];
      ofm_pkg::ADDR_ACTIVE_BASE + ofm_pkg::ADDR_OUTPUTS:
        rdata[15:0] = active_words[79:64];
      default:                      hit = 1'b0;
    endcase
    if (psel && !penable && !pwrite) begin
      prdata_next = rdata;
    end
    if (wr && paddr <= ofm_pkg::ADDR_OUTPUTS && paddr[1:0] == 2'b00) begin
      for (int b = 0; b < 2; b++) begin
        if (pstrb[b]) begin
          words_next[paddr[7:2]*16 + b*8 +: 8] = pwdata[b*8 +: 8];
        end
      end
    end
    if (wr && paddr == ofm_pkg::ADDR_CONTROL && pstrb[0]) begin
      restart_next = pwdata[ofm_pkg::CTL_RESTART_BIT];
      profile_next = pwdata[ofm_pkg::CTL_PROFILE_BIT];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      words_reg   <= {ofm_pkg::RST_OUTPUTS, ofm_pkg::RST_BANK_LATCH,
                      ofm_pkg::RST_CURRENT_LIMITS, ofm_pkg::RST_SPEED_INTEGRAL,
                      ofm_pkg::RST_ACCEL_GAIN};
      profile_reg <= 1'b0;
      restart_reg <= 1'b0;
      prdata      <= 32'h0000_0000;
    end else begin
      words_reg   <= words_next;
      profile_reg <= profile_next;
      restart_reg <= restart_next;
      prdata      <= prdata_next;
    end
  end

  // read data latched in setup, so access phase completes at once
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !hit;
  assign pending_words = words_reg;
  assign restart_pulse = restart_reg;
  assign profile_sel   = profile_reg;
endmodule
`default_nettype wire

// ---- rtl/ofm_func_slot.sv ----
/*
  One mapped function: picks the chosen option bit on each command.
  Assumes position and enable come from the latched active allocation.
*/
`timescale 1ns/1ps
`default_nettype none
module ofm_func_slot (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] option_field,
  input  wire logic [3:0]  bit_pos,
  input  wire logic [3:0]  max_pos,
  input  wire logic        alloc_en,
  input  wire logic        legacy,
  output logic             flag
);
  logic flag_reg;
  logic flag_next;
  logic usable;

  always_comb begin
    // positions beyond the legal range are treated as unallocated
    usable    = alloc_en && legacy && (bit_pos <= max_pos);
    flag_next = flag_reg;
    if (!usable) begin
      flag_next = 1'b0;
    end else if (cmd_valid) begin
      flag_next = option_field[bit_pos];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;
endmodule
`default_nettype wire

// ---- rtl/ofm_mapper.sv ----
/*
  Option-field bit mapper top: APB registers, restart-latched active
  allocation and one slot per mapped function.
  Assumes cmd_valid pulses one cycle with the received option field.
*/
`timescale 1ns/1ps
`default_nettype none
module ofm_mapper (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] option_field,
  output logic             accel_filter_select,
  output logic             gain_set_select,
  output logic             speed_loop_p_mode,
  output logic             position_integral_clear,
  output logic             forward_current_limit,
  output logic             reverse_current_limit,
  output logic             parameter_bank_select,
  output logic             latch_inhibit,
  output logic             general_output
);
  logic [79:0]  pending_words;
  logic [79:0]  active_reg;
  logic [79:0]  active_next;
  logic         legacy_reg;
  logic         legacy_next;
  logic         restart_pulse;
  logic         profile_sel;
  logic [8:0]   flags;
  logic [35:0]  pos_vec;
  logic [8:0]   en_vec;
  logic [35:0]  max_vec;

  ofm_apb_regs u_regs (
    .clock         (clock),
    .arst_n        (arst_n),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .pstrb         (pstrb),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .active_words  (active_reg),
    .flags         (flags),
    .legacy_active (legacy_reg),
    .pending_words (pending_words),
    .restart_pulse (restart_pulse),
    .profile_sel   (profile_sel)
  );

  // pending settings only reach the mapper on a restart
  always_comb begin
    active_next = active_reg;
    legacy_next = legacy_reg;
    if (restart_pulse) begin
      active_next = pending_words;
      legacy_next = profile_sel;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      active_reg <= {ofm_pkg::RST_OUTPUTS, ofm_pkg::RST_BANK_LATCH,
                     ofm_pkg::RST_CURRENT_LIMITS, ofm_pkg::RST_SPEED_INTEGRAL,
                     ofm_pkg::RST_ACCEL_GAIN};
      legacy_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
      legacy_reg <= legacy_next;
    end
  end

  // slots 0..7: slot n uses word n/2, low digits for even n, high digits for odd n
  always_comb begin
    for (int n = 0; n < ofm_pkg::NUM_FUNC - 1; n++) begin
      if (n % 2 == 0) begin
        pos_vec[n*4 +: 4] = active_reg[(n/2)*16 + ofm_pkg::LO_POS_LSB +: 4];
        en_vec[n]         = active_reg[(n/2)*16 + ofm_pkg::LO_EN_BIT];
      end else begin
        pos_vec[n*4 +: 4] = active_reg[(n/2)*16 + ofm_pkg::HI_POS_LSB +: 4];
        en_vec[n]         = active_reg[(n/2)*16 + ofm_pkg::HI_EN_BIT];
      end
    end
    // the output word uses its high digits; low digits are reserved
    pos_vec[32 +: 4] = active_reg[64 + ofm_pkg::HI_POS_LSB +: 4];
    en_vec[8]        = active_reg[64 + ofm_pkg::HI_EN_BIT];
    max_vec = {ofm_pkg::MAX_POS_OUT, ofm_pkg::MAX_POS_FULL, ofm_pkg::MAX_POS_BANK,
               ofm_pkg::MAX_POS_FULL, ofm_pkg::MAX_POS_FULL, ofm_pkg::MAX_POS_FULL,
               ofm_pkg::MAX_POS_FULL, ofm_pkg::MAX_POS_GAIN,
               ofm_pkg::MAX_POS_ACCEL};
  end

  genvar g;
  generate
    for (g = 0; g < ofm_pkg::NUM_FUNC; g++) begin : g_slot
      ofm_func_slot u_slot (
        .clock        (clock),
        .arst_n       (arst_n),
        .cmd_valid    (cmd_valid),
        .option_field (option_field),
        .bit_pos      (pos_vec[g*4 +: 4]),
        .max_pos      (max_vec[g*4 +: 4]),
        .alloc_en     (en_vec[g]),
        .legacy       (legacy_reg),
        .flag         (flags[g])
      );
    end
  endgenerate

  assign accel_filter_select     = flags[0];
  assign gain_set_select         = flags[1];
  assign speed_loop_p_mode       = flags[2];
  assign position_integral_clear = flags[3];
  assign forward_current_limit   = flags[4];
  assign reverse_current_limit   = flags[5];
  assign parameter_bank_select   = flags[6];
  assign latch_inhibit           = flags[7];
  assign general_output          = flags[8];
endmodule
`default_nettype wire

// ---- rtl/ofm_pkg.sv ----
/*
  Constants for the option-field bit mapper: register offsets, reset values,
  digit layout of the allocation words, profile codes.
  Assumes a single clock domain and an APB master with 32-bit data.
*/
// Notes on behaviour
// - accel filter flag from chosen bit 0..E
// - gain select flag from chosen bit 0..E
// - speed P/PI flag from bit 0..F
// - position integral clear from bit 0..F
// - allocation changes apply after restart; default 1813
// - allocation used only in legacy profile
package ofm_pkg;
  localparam logic [7:0]  ADDR_ACCEL_GAIN      = 8'h00;
  localparam logic [7:0]  ADDR_SPEED_INTEGRAL  = 8'h04;
  localparam logic [7:0]  ADDR_CURRENT_LIMITS  = 8'h08;
  localparam logic [7:0]  ADDR_BANK_LATCH      = 8'h0c;
  localparam logic [7:0]  ADDR_OUTPUTS         = 8'h10;
  localparam logic [7:0]  ADDR_CONTROL         = 8'h14;
  localparam logic [7:0]  ADDR_STATUS          = 8'h18;
  localparam logic [7:0]  ADDR_ACTIVE_BASE     = 8'h20;

  localparam logic [15:0] RST_ACCEL_GAIN       = 16'h1813;
  localparam logic [15:0] RST_SPEED_INTEGRAL   = 16'h1d1c;
  localparam logic [15:0] RST_CURRENT_LIMITS   = 16'h1f1e;
  localparam logic [15:0] RST_BANK_LATCH       = 16'h0000;
  localparam logic [15:0] RST_OUTPUTS          = 16'h0000;

  // digit layout inside one allocation word
  localparam int          LO_POS_LSB           = 0;
  localparam int          LO_EN_BIT            = 4;
  localparam int          HI_POS_LSB           = 8;
  localparam int          HI_EN_BIT            = 12;

  localparam logic [3:0]  MAX_POS_ACCEL        = 4'he;
  localparam logic [3:0]  MAX_POS_GAIN         = 4'he;
  localparam logic [3:0]  MAX_POS_FULL         = 4'hf;
  localparam logic [3:0]  MAX_POS_BANK         = 4'hc;
  localparam logic [3:0]  MAX_POS_OUT          = 4'hd;

  localparam int          NUM_FUNC             = 9;
  localparam int          NUM_WORDS            = 5;

  // control register fields
  localparam int          CTL_RESTART_BIT      = 0;
  localparam int          CTL_PROFILE_BIT      = 1;

  typedef enum logic {
    OFM_PROFILE_STANDARD,
    OFM_PROFILE_LEGACY
  } ofm_profile_t;
endpackage

// ---- test/ofm_host_model.sv ----
/* host side: issues one-cycle commands with an option field
   assumes the bench raises send for one cycle per command */
`timescale 1ns/1ps
`default_nettype none
module ofm_host_model (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        send,
  input  wire logic [15:0] data,
  output logic             cmd_valid,
  output logic [15:0]      option_field
);
  logic        valid_next;
  logic [15:0] field_next;
  // field scrambled between commands so a stale value never passes
  always_comb begin
    valid_next = send;
    field_next = send ? data : ~option_field;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_valid    <= 1'b0;
      option_field <= 16'h0000;
    end else begin
      cmd_valid    <= valid_next;
      option_field <= field_next;
    end
  end
endmodule
`default_nettype wire

// ---- test/ofm_mapper_properties.sv ----
/* port checker for ofm_mapper, bound below
   assumes profile and restart bits are written together */
`timescale 1ns/1ps
`default_nettype none
module ofm_mapper_properties (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cmd_valid,
  input wire logic [15:0] option_field,
  input wire logic        accel_filter_select,
  input wire logic        gain_set_select,
  input wire logic        speed_loop_p_mode,
  input wire logic        position_integral_clear,
  input wire logic        forward_current_limit,
  input wire logic        reverse_current_limit,
  input wire logic        parameter_bank_select,
  input wire logic        latch_inhibit,
  input wire logic        general_output
);
  wire logic [8:0] flags = {accel_filter_select, gain_set_select, speed_loop_p_mode,
    position_integral_clear, forward_current_limit, reverse_current_limit,
    parameter_bank_select, latch_inhibit, general_output};
  wire logic       ctl_wr = psel && penable && pwrite && paddr == 8'h14;
  logic            act_leg_reg;
  logic            act_leg_next;
  // one edge ahead of the design's copy, hence the margins below
  always_comb act_leg_next = (ctl_wr && pwdata[0]) ? pwdata[1] : act_leg_reg;
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) act_leg_reg <= 1'b0;
    else act_leg_reg <= act_leg_next;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  AST_PREADY_UP: assert property (psel && penable |-> pready)
    else $error("pready low");
  AST_ERR_UNMAPPED: assert property (psel && penable && !pwrite && paddr > 8'h30
    |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped read not refused");
  AST_NO_ERR_MAPPED: assert property (psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'b00
    |-> !pslverr) else $error("mapped access refused");
  AST_ERR_QUAL: assert property (pslverr |-> psel && penable)
    else $error("stray pslverr");
  AST_UPPER_ZERO: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_RESTART_RD0: assert property (psel && penable && !pwrite && paddr == 8'h14
    |-> !prdata[0]) else $error("restart bit reads one");
  AST_FLAGS_HOLD: assert property (!$past(cmd_valid) && !$past(psel) && !$past(psel, 2)
    && !$past(psel, 3) |-> $stable(flags)) else $error("flags moved without cause");
  AST_STANDARD_ZERO: assert property (!act_leg_reg && !$past(act_leg_reg, 2)
    && $past(cmd_valid) |-> flags == 9'h000) else $error("flags set outside legacy");
  AST_ZERO_OPT: assert property ($past(cmd_valid) && $past(option_field) == 16'h0000
    |-> flags == 9'h000) else $error("flag set from zero field");
  cover property (act_leg_reg && cmd_valid);
  cover property (pslverr);
  cover property ($rose(accel_filter_select));
endmodule
bind ofm_mapper ofm_mapper_properties i_ofm_mapper_properties (.*);
`default_nettype wire

// ---- test/testbench.sv ----
/* bench for ofm_mapper: apb tasks, host model, expected flags
   assumes zero-wait apb and flags one edge after a command */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clock, arst_n, psel, penable, pwrite, send, cmd_valid, pready, pslverr, leg, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] sdata, option_field, o, w [5], pw [5];
  wire  [8:0]  flg;
  int          err_count, num_checks, cyc, seed, i, k;
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  ofm_host_model i_ofm_host_model (.clock(clock), .arst_n(arst_n), .send(send), .data(sdata),
    .cmd_valid(cmd_valid), .option_field(option_field));
  ofm_mapper i_ofm_mapper (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .option_field(option_field),
    .accel_filter_select(flg[8]), .gain_set_select(flg[7]), .speed_loop_p_mode(flg[6]),
    .position_integral_clear(flg[5]), .forward_current_limit(flg[4]),
    .reverse_current_limit(flg[3]), .parameter_bank_select(flg[2]), .latch_inhibit(flg[1]),
    .general_output(flg[0]));
  function automatic logic pick(logic [15:0] wd, logic hi, logic [3:0] mx, logic [15:0] v);
    logic [3:0] p;
    p = hi ? wd[11:8] : wd[3:0];
    return (hi ? wd[12] : wd[4]) && p <= mx && v[p];
  endfunction
  function automatic logic [8:0] expect_flags(logic [15:0] v);
    return leg ? {pick(w[0], 1'b0, 4'he, v), pick(w[0], 1'b1, 4'he, v),
      pick(w[1], 1'b0, 4'hf, v), pick(w[1], 1'b1, 4'hf, v), pick(w[2], 1'b0, 4'hf, v),
      pick(w[2], 1'b1, 4'hf, v), pick(w[3], 1'b0, 4'hc, v), pick(w[3], 1'b1, 4'hf, v),
      pick(w[4], 1'b1, 4'hd, v)} : 9'h000;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [15:0] ex, input logic ee);
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, {16'h0000, ex});
    chk({31'h0, e}, {31'h0, ee});
  endtask
  task automatic cmd(input logic [15:0] v);
    @(posedge clock);
    send <= 1'b1;
    sdata <= v;
    @(posedge clock);
    send <= 1'b0;
    repeat (2) @(negedge clock);
    chk({23'h0, flg}, {23'h0, expect_flags(v)});
  endtask
  task automatic restart(input logic l);
    apb(1'b1, 8'h14, {30'h0, l, 1'b0}, q, e);
    apb(1'b1, 8'h14, {30'h0, l, 1'b1}, q, e);
    rd_cmp(8'h14, {14'h0000, l, 1'b0}, 1'b0);
    w = pw;
    leg = l;
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      print_verdict;
    end
  end
  initial begin
    seed = 80;
    {arst_n, psel, penable, pwrite, send, leg} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sdata = 16'h0000;
    w = '{16'h1813, 16'h1d1c, 16'h1f1e, 16'h0000, 16'h0000};
    pw = w;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rd_cmp(8'(i * 4), w[i], 1'b0);
      rd_cmp(8'(32 + i * 4), w[i], 1'b0);
    end
    rd_cmp(8'h18, 16'h0000, 1'b0);
    rd_cmp(8'h1c, 16'h0000, 1'b1);
    rd_cmp(8'h40, 16'h0000, 1'b1);
    cmd(16'hffff);
    restart(1'b1);
    cmd(16'hffff);
    // default mapping in legacy: first six functions up, legacy bit up
    rd_cmp(8'h18, 16'h023f, 1'b0);
    for (i = 0; i < 8; i++) begin
      for (k = 0; k < 5; k++) pw[k] = 16'($random(seed)) & (k == 4 ? 16'h1f00 : 16'h1f1f);
      if (i == 0) pw = '{16'h1f1e, 16'h1f10, 16'h0f1f, 16'h1d1c, 16'h1d00};
      for (k = 0; k < 5; k++) apb(1'b1, 8'(k * 4), {16'h0000, pw[k]}, q, e);
      cmd(16'hffff);
      restart(1'b1);
      for (k = 0; k < 5; k++) rd_cmp(8'(32 + k * 4), w[k], 1'b0);
      repeat (4) begin
        o = 16'($random(seed));
        cmd(o);
      end
    end
    cmd(16'h0000);
    restart(1'b0);
    cmd(16'hffff);
    print_verdict;
  end
endmodule
`default_nettype wire
